/* File: shared/rdt_defines.svh */
// Register offsets, field positions, reset values and widths of the reload down timer.
// Assumes a 16-bit register port with byte addresses in steps of four.
`ifndef RDT_DEFINES_SVH
`define RDT_DEFINES_SVH

`define RDT_ADDR_W 8
`define RDT_DATA_W 16

`define RDT_OFF_CLK_SEL 8'h00
`define RDT_OFF_MODE 8'h04
`define RDT_OFF_CTRL 8'h08
`define RDT_OFF_RELOAD 8'h0c
`define RDT_OFF_COUNT 8'h10
`define RDT_OFF_UF_FLAG 8'h14
`define RDT_OFF_UF_IE 8'h18

`define RDT_BIT_DEBUG_RUN 8
`define RDT_DIV_LSB 4
`define RDT_DIV_MSB 7
`define RDT_SRC_LSB 0
`define RDT_SRC_MSB 1
`define RDT_BIT_ONE_SHOT 0
`define RDT_BIT_RUN 8
`define RDT_BIT_PRESET 1
`define RDT_BIT_ENABLE 0
`define RDT_BIT_UF 0

`define RDT_RELOAD_RST 16'hffff
`define RDT_COUNT_RST 16'hffff
`define RDT_DIV_MAX_LOW 4'h8
`define RDT_DIV_MAX_EXT 4'h0

`endif

/* File: shared/rdt_pkg.sv */
// Types shared by the reload down timer.
// Assumes rdt_defines.svh on the include path.
`include "rdt_defines.svh"

package rdt_pkg;

  typedef enum logic [1:0] {
    RDT_SRC_INTERNAL = 2'b00,
    RDT_SRC_LOW_SPEED = 2'b01,
    RDT_SRC_HIGH_SPEED = 2'b10,
    RDT_SRC_EXTERNAL = 2'b11
  } rdt_src_t;

  typedef struct packed {
    logic [`RDT_ADDR_W-1:0] addr;
    logic [`RDT_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } rdt_bus_req_t;

endpackage

/* File: rtl/rdt_timer.sv */
// One channel of the 16-bit reload down timer with its register port.
// Assumes source clocks arrive asynchronously; debug_halt is on clk_sys.
//
// How it works
// - Two-bit source code picks internal, low-speed, high-speed or external clock.
// - Selected source divided by two to the divider code, limited per source.
// - Code three uses event pin on event channels, external clock otherwise.
// - A write never takes a source absent from the chip; such writes keep old source.
// - Mode bit 0 clear gives repeat mode, set gives one-shot mode.
// - Writing run 1 starts counting only when the same write sets enable.
// - Writing run 0 stops counting; run bit reads back running state.
// - One-shot underflow stops the counter and clears the run bit.
// - Writing preset 1 with enable loads reload into counter; 0 does nothing.
// - Preset bit reads 1 while the load is pending, then clears itself.
// - Channel enable gates the operating clock of the channel.
// - Reload resets to ffff and loads on preset and on every underflow.
// - Counter value readable in a read-only register resetting to ffff.
// - Underflow sets the flag; writing 1 clears it, writing 0 keeps it.
// - Interrupt enable bit permits or blocks underflow interrupts.
// - With debug run clear, debug halt freezes the channel.
// - With debug run set, the channel keeps counting in debug halt.
// - In repeat mode underflow reloads and counting goes on.
// - Interrupt request is high only when flag and enable were both set one cycle earlier.
// - Underflows are reload plus one divided ticks apart.
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module rdt_timer
  import rdt_pkg::*;
#(
  parameter logic [3:0] SRC_PRESENT = 4'b1111,
  parameter bit HAS_EVENT = 1'b0
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Register port
  input wire rdt_bus_req_t bus_req,
  output logic [`RDT_DATA_W-1:0] rdata,
  // Clock sources, asynchronous
  input wire logic internal_oscillator,
  input wire logic low_speed_oscillator,
  input wire logic high_speed_oscillator,
  input wire logic external_clock_input,
  input wire logic event_input_pin,
  // Processor debug state
  input wire logic debug_halt,
  // Events
  output logic irq,
  output logic underflow_pulse
);

  localparam int NSRC = 5;

  function automatic logic hit(input logic [`RDT_ADDR_W-1:0] a,
                               input logic [`RDT_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [3:0] limit_div(input rdt_src_t s, input logic [3:0] code);
    limit_div = code;
    case (s)
      RDT_SRC_LOW_SPEED: if (code > `RDT_DIV_MAX_LOW) limit_div = `RDT_DIV_MAX_LOW;
      RDT_SRC_EXTERNAL: limit_div = `RDT_DIV_MAX_EXT;
      default: limit_div = code;
    endcase
  endfunction

  logic debug_run_ff;
  logic [3:0] div_code_ff;
  rdt_src_t src_ff;
  logic one_shot_ff;
  logic run_ff;
  logic preset_busy_ff;
  logic enable_ff;
  logic [15:0] reload_ff;
  logic [15:0] count_ff;
  logic uf_flag_ff;
  logic uf_ie_ff;
  logic [14:0] prescale_ff;
  logic [NSRC-1:0] sync1_ff;
  logic [NSRC-1:0] sync2_ff;
  logic [NSRC-1:0] sync3_ff;
  logic [`RDT_DATA_W-1:0] rdata_ff;
  logic irq_ff;
  logic uf_pulse_ff;

  logic wr_clk, wr_mode, wr_ctrl, wr_reload, wr_flag, wr_ie;
  logic clk_on;
  logic src_edge;
  logic [14:0] div_mask;
  logic tick;
  logic uf_now;
  logic en_now;
  logic [NSRC-1:0] src_in;
  logic [NSRC-1:0] src_rise;

  assign wr_clk = bus_req.wr && hit(bus_req.addr, `RDT_OFF_CLK_SEL);
  assign wr_mode = bus_req.wr && hit(bus_req.addr, `RDT_OFF_MODE);
  assign wr_ctrl = bus_req.wr && hit(bus_req.addr, `RDT_OFF_CTRL);
  assign wr_reload = bus_req.wr && hit(bus_req.addr, `RDT_OFF_RELOAD);
  assign wr_flag = bus_req.wr && hit(bus_req.addr, `RDT_OFF_UF_FLAG);
  assign wr_ie = bus_req.wr && hit(bus_req.addr, `RDT_OFF_UF_IE);

  // Operating clock gate
  assign clk_on = enable_ff && (!debug_halt || debug_run_ff);

  // Source synchronisers
  assign src_in = {event_input_pin, external_clock_input, high_speed_oscillator,
                   low_speed_oscillator, internal_oscillator};

  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++)
    begin : g_sync
      always_ff @(posedge clk_sys or negedge rstn)
      begin
        if (!rstn)
        begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
          sync3_ff[gi] <= 1'b0;
        end
        else
        begin
          sync1_ff[gi] <= src_in[gi];
          sync2_ff[gi] <= sync1_ff[gi];
          sync3_ff[gi] <= sync2_ff[gi];
        end
      end
      assign src_rise[gi] = sync2_ff[gi] && !sync3_ff[gi];
    end
  endgenerate

  always_comb
  begin
    case (src_ff)
      RDT_SRC_INTERNAL: src_edge = src_rise[0];
      RDT_SRC_LOW_SPEED: src_edge = src_rise[1];
      RDT_SRC_HIGH_SPEED: src_edge = src_rise[2];
      RDT_SRC_EXTERNAL: src_edge = HAS_EVENT ? src_rise[4] : src_rise[3];
      default: src_edge = 1'b0;
    endcase
  end

  // Divider
  assign div_mask = 15'((16'h0001 << limit_div(src_ff, div_code_ff)) - 16'h0001);
  assign tick = clk_on && src_edge && ((prescale_ff & div_mask) == div_mask);
  assign uf_now = tick && run_ff && (count_ff == 16'h0000);

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      prescale_ff <= 15'h0000;
    else if (!run_ff)
      prescale_ff <= 15'h0000;
    else if (clk_on && src_edge)
      prescale_ff <= tick ? 15'h0000 : prescale_ff + 15'h0001;
  end

  // Clock select register
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      debug_run_ff <= 1'b0;
      div_code_ff <= 4'h0;
      src_ff <= RDT_SRC_INTERNAL;
    end
    else if (wr_clk)
    begin
      debug_run_ff <= bus_req.wdata[`RDT_BIT_DEBUG_RUN];
      div_code_ff <= bus_req.wdata[`RDT_DIV_MSB:`RDT_DIV_LSB];
      if (SRC_PRESENT[bus_req.wdata[`RDT_SRC_MSB:`RDT_SRC_LSB]])
        src_ff <= rdt_src_t'(bus_req.wdata[`RDT_SRC_MSB:`RDT_SRC_LSB]);
    end
  end

  // Mode and interrupt enable
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      one_shot_ff <= 1'b0;
      uf_ie_ff <= 1'b0;
    end
    else
    begin
      if (wr_mode)
        one_shot_ff <= bus_req.wdata[`RDT_BIT_ONE_SHOT];
      if (wr_ie)
        uf_ie_ff <= bus_req.wdata[`RDT_BIT_UF];
    end
  end

  // Control register
  assign en_now = wr_ctrl ? bus_req.wdata[`RDT_BIT_ENABLE] : enable_ff;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      enable_ff <= 1'b0;
    else if (wr_ctrl)
      enable_ff <= bus_req.wdata[`RDT_BIT_ENABLE];
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      run_ff <= 1'b0;
    else if (wr_ctrl && !bus_req.wdata[`RDT_BIT_RUN])
      run_ff <= 1'b0;
    else if (wr_ctrl && bus_req.wdata[`RDT_BIT_RUN] && en_now)
      run_ff <= 1'b1;
    else if (uf_now && one_shot_ff)
      run_ff <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      preset_busy_ff <= 1'b0;
    else if (wr_ctrl && bus_req.wdata[`RDT_BIT_PRESET] && en_now)
      preset_busy_ff <= 1'b1;
    else if (clk_on)
      preset_busy_ff <= 1'b0;
  end

  // Reload and counter
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      reload_ff <= `RDT_RELOAD_RST;
    else if (wr_reload)
      reload_ff <= bus_req.wdata;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      count_ff <= `RDT_COUNT_RST;
    else if (preset_busy_ff && clk_on)
      count_ff <= reload_ff;
    else if (uf_now)
      count_ff <= reload_ff;
    else if (tick && run_ff)
      count_ff <= count_ff - 16'h0001;
  end

  // Underflow flag, set wins over clear
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      uf_flag_ff <= 1'b0;
    else if (uf_now)
      uf_flag_ff <= 1'b1;
    else if (wr_flag && bus_req.wdata[`RDT_BIT_UF])
      uf_flag_ff <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_ff <= 1'b0;
      uf_pulse_ff <= 1'b0;
    end
    else
    begin
      irq_ff <= uf_flag_ff && uf_ie_ff;
      uf_pulse_ff <= uf_now;
    end
  end

  // Read port
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rdata_ff <= 16'h0000;
    else if (bus_req.rd)
    begin
      case (bus_req.addr)
        `RDT_OFF_CLK_SEL: rdata_ff <= {7'h00, debug_run_ff, div_code_ff, 2'b00, src_ff};
        `RDT_OFF_MODE: rdata_ff <= {15'h0000, one_shot_ff};
        `RDT_OFF_CTRL: rdata_ff <= {7'h00, run_ff, 6'h00, preset_busy_ff, enable_ff};
        `RDT_OFF_RELOAD: rdata_ff <= reload_ff;
        `RDT_OFF_COUNT: rdata_ff <= count_ff;
        `RDT_OFF_UF_FLAG: rdata_ff <= {15'h0000, uf_flag_ff};
        `RDT_OFF_UF_IE: rdata_ff <= {15'h0000, uf_ie_ff};
        default: rdata_ff <= 16'h0000;
      endcase
    end
    else
      rdata_ff <= 16'h0000;
  end

  assign rdata = rdata_ff;
  assign irq = irq_ff;
  assign underflow_pulse = uf_pulse_ff;

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  property p_irq_gate;
    irq_ff |-> $past(uf_flag_ff) && $past(uf_ie_ff);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without flag and enable");

  property p_uf_reload;
    uf_now && !(preset_busy_ff && clk_on) |=> count_ff == $past(reload_ff);
  endproperty
  a_uf_reload: assert property (p_uf_reload) else $error("underflow did not reload");

  property p_decrement;
    tick && run_ff && count_ff != 16'h0000 && !preset_busy_ff
      |=> count_ff == $past(count_ff) - 16'h0001;
  endproperty
  a_decrement: assert property (p_decrement) else $error("tick did not decrement");

  property p_one_shot_stop;
    uf_now && one_shot_ff && !wr_ctrl |=> !run_ff;
  endproperty
  a_one_shot_stop: assert property (p_one_shot_stop) else $error("one-shot kept running");

  property p_repeat_continue;
    uf_now && !one_shot_ff && !wr_ctrl |=> run_ff;
  endproperty
  a_repeat_continue: assert property (p_repeat_continue) else $error("repeat stopped");

  sequence s_preset_req;
    wr_ctrl && bus_req.wdata[`RDT_BIT_PRESET] && en_now && !debug_halt;
  endsequence
  sequence s_preset_done;
    preset_busy_ff ##1 (!preset_busy_ff && count_ff == $past(reload_ff));
  endsequence
  property p_preset;
    s_preset_req ##0 (wr_ctrl && bus_req.wdata[`RDT_BIT_ENABLE]) ##1 !debug_halt && !wr_ctrl
      |-> s_preset_done;
  endproperty
  a_preset: assert property (p_preset) else $error("preset did not load");

  property p_flag_set;
    uf_now |=> uf_flag_ff;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("underflow flag lost");

  property p_flag_clear;
    wr_flag && bus_req.wdata[`RDT_BIT_UF] && !uf_now |=> !uf_flag_ff;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_freeze;
    !clk_on |=> $stable(count_ff);
  endproperty
  a_freeze: assert property (p_freeze) else $error("counter moved while gated");

  property p_start_needs_enable;
    wr_ctrl && !bus_req.wdata[`RDT_BIT_ENABLE] && !run_ff |=> !run_ff;
  endproperty
  a_start_needs_enable: assert property (p_start_needs_enable) else $error("ran without enable");

  property p_count_read;
    bus_req.rd && bus_req.addr == `RDT_OFF_COUNT |=> rdata_ff == $past(count_ff);
  endproperty
  a_count_read: assert property (p_count_read) else $error("counter read mismatch");

endmodule

`default_nettype wire

/* File: bench/sixteen_bit_reload_down_timer_tb.sv */
// Self-checking bench for the reload down timer channel.
// Assumes rdt_timer with high-speed source absent and no event counting.
`timescale 1ns/1ps
`default_nettype none
`include "rdt_defines.svh"

module sixteen_bit_reload_down_timer_tb
  import rdt_pkg::*;
;
  typedef struct {
    string nm;
    logic [15:0] d;
    logic [15:0] irq;
    logic [15:0] uf;
  } rdt_exp_t;

  localparam int T_SRC[3] = '{0, 1, 3};
  localparam int T_DIV[3] = '{3, 15, 5};
  localparam int T_EFF[3] = '{3, 8, 0};

  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  rdt_bus_req_t req = '0;
  logic [4:0] src = '0;
  logic debug_halt = 1'b0;
  logic [`RDT_DATA_W-1:0] rdata;
  logic irq;
  logic underflow_pulse;
  logic rd_q = 1'b0;
  int mismatches = 0;
  int comparisons = 0;
  rdt_exp_t exp_q[$];
  logic [15:0] m_cnt = 16'hffff;
  logic [15:0] m_rld = 16'hffff;
  logic [15:0] m_uf = 16'h0000;
  logic [15:0] uf_seen = 16'h0000;
  bit m_run = 1'b0;
  bit m_one = 1'b0;
  bit m_flag = 1'b0;
  bit m_ie = 1'b0;
  int n;
  int seed_v;

  always #4 clk_sys = ~clk_sys;

  rdt_timer #(.SRC_PRESENT(4'b1011), .HAS_EVENT(1'b0)) i_dut (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .bus_req(req),
    .rdata(rdata),
    .internal_oscillator(src[0]),
    .low_speed_oscillator(src[1]),
    .high_speed_oscillator(src[2]),
    .external_clock_input(src[3]),
    .event_input_pin(src[4]),
    .debug_halt(debug_halt),
    .irq(irq),
    .underflow_pulse(underflow_pulse)
  );

  task automatic report_and_stop();
    if (mismatches == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (e !== g)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Read results land one cycle after the strobe
  always @(posedge clk_sys) rd_q <= req.rd;
  always @(posedge clk_sys) if (underflow_pulse === 1'b1) uf_seen <= uf_seen + 16'h0001;

  always @(negedge clk_sys)
  begin
    rdt_exp_t e;
    if (rd_q === 1'b1)
    begin
      e = exp_q.pop_front();
      cmp(e.nm, e.d, rdata);
      cmp({e.nm, " irq"}, e.irq, {15'h0000, irq});
      cmp({e.nm, " underflows"}, e.uf, uf_seen);
    end
  end

  function automatic void m_tick();
    if (m_run)
    begin
      if (m_cnt == 16'h0000)
      begin
        m_cnt = m_rld;
        m_uf = m_uf + 16'h0001;
        m_flag = 1'b1;
        if (m_one)
          m_run = 1'b0;
      end
      else
        m_cnt = m_cnt - 16'h0001;
    end
  endfunction

  // Bus tasks hold the strobe; idle or tick releases it
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] d, input string nm);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    exp_q.push_back('{nm, d, {15'h0000, m_flag & m_ie}, m_uf});
    @(posedge clk_sys);
  endtask

  task automatic idle(input int c);
    req <= '0;
    repeat (c) @(posedge clk_sys);
  endtask

  // Source pulses, 2^eff per tick, then sync settle
  task automatic tick(input int pin, input int eff, input int t, input bit counts);
    req <= '0;
    repeat (t << eff)
    begin
      src[pin] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      src[pin] <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    repeat (6) @(posedge clk_sys);
    if (counts)
      repeat (t) m_tick();
  endtask

  initial
  begin
    #480000;
    mismatches++;
    report_and_stop();
  end

  initial
  begin
    seed_v = $urandom(73336);
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rd(`RDT_OFF_CLK_SEL, 16'h0000, "clk_sel");
    rd(`RDT_OFF_MODE, 16'h0000, "mode");
    rd(`RDT_OFF_CTRL, 16'h0000, "ctrl");
    rd(`RDT_OFF_RELOAD, 16'hffff, "reload");
    rd(`RDT_OFF_COUNT, 16'hffff, "count");
    rd(`RDT_OFF_UF_FLAG, 16'h0000, "flag");
    rd(`RDT_OFF_UF_IE, 16'h0000, "irq_en");
    rd(8'h1c, 16'h0000, "unmapped");
    wr(`RDT_OFF_COUNT, 16'h1234);
    rd(`RDT_OFF_COUNT, 16'hffff, "count read-only");
    wr(`RDT_OFF_CTRL, 16'h0102);
    rd(`RDT_OFF_CTRL, 16'h0000, "ctrl no enable");
    rd(`RDT_OFF_COUNT, 16'hffff, "count no enable");
    wr(`RDT_OFF_RELOAD, 16'h0005);
    wr(`RDT_OFF_CTRL, 16'h0003);
    rd(`RDT_OFF_CTRL, 16'h0003, "preset busy");
    rd(`RDT_OFF_CTRL, 16'h0001, "preset done");
    rd(`RDT_OFF_COUNT, 16'h0005, "count preset");
    m_cnt = 16'h0005;
    wr(`RDT_OFF_RELOAD, 16'h0007);
    wr(`RDT_OFF_CTRL, 16'h0001);
    idle(2);
    rd(`RDT_OFF_COUNT, 16'h0005, "preset zero");
    wr(`RDT_OFF_CLK_SEL, 16'h0011);
    wr(`RDT_OFF_CLK_SEL, 16'h0032);
    rd(`RDT_OFF_CLK_SEL, 16'h0031, "absent source");
    for (int i = 0; i < 3; i++)
    begin
      wr(`RDT_OFF_CLK_SEL, 16'((T_DIV[i] << 4) | T_SRC[i]));
      m_rld = 16'($urandom_range(3, 1));
      wr(`RDT_OFF_RELOAD, m_rld);
      wr(`RDT_OFF_CTRL, 16'h0103);
      m_cnt = m_rld;
      m_run = 1'b1;
      // Event pin must not count on a channel without event counting
      if (T_SRC[i] == 3)
        tick(4, 0, 3, 1'b0);
      n = int'(m_rld) + 1 + int'($urandom_range(2, 0));
      tick(T_SRC[i], T_EFF[i], n, 1'b1);
      wr(`RDT_OFF_CTRL, 16'h0001);
      m_run = 1'b0;
      idle(2);
      rd(`RDT_OFF_COUNT, m_cnt, "count after ticks");
      rd(`RDT_OFF_CTRL, 16'h0001, "run stopped");
    end
    rd(`RDT_OFF_UF_FLAG, 16'h0001, "flag set");
    wr(`RDT_OFF_UF_FLAG, 16'h0000);
    rd(`RDT_OFF_UF_FLAG, 16'h0001, "flag write 0");
    wr(`RDT_OFF_UF_FLAG, 16'h0001);
    m_flag = 1'b0;
    rd(`RDT_OFF_UF_FLAG, 16'h0000, "flag clear");
    wr(`RDT_OFF_UF_IE, 16'h0001);
    m_ie = 1'b1;
    rd(`RDT_OFF_UF_IE, 16'h0001, "irq_en set");
    wr(`RDT_OFF_MODE, 16'h0001);
    rd(`RDT_OFF_MODE, 16'h0001, "one-shot mode");
    wr(`RDT_OFF_CLK_SEL, 16'h0000);
    wr(`RDT_OFF_RELOAD, 16'h0002);
    wr(`RDT_OFF_CTRL, 16'h0103);
    m_rld = 16'h0002;
    m_cnt = 16'h0002;
    m_run = 1'b1;
    m_one = 1'b1;
    tick(0, 0, 5, 1'b1);
    rd(`RDT_OFF_CTRL, 16'h0001, "one-shot run clear");
    rd(`RDT_OFF_COUNT, m_cnt, "one-shot count");
    wr(`RDT_OFF_MODE, 16'h0000);
    wr(`RDT_OFF_CTRL, 16'h0101);
    m_one = 1'b0;
    m_run = 1'b1;
    debug_halt <= 1'b1;
    tick(0, 0, 3, 1'b0);
    rd(`RDT_OFF_COUNT, m_cnt, "debug frozen");
    wr(`RDT_OFF_CLK_SEL, 16'h0100);
    tick(0, 0, 3, 1'b1);
    rd(`RDT_OFF_COUNT, m_cnt, "debug runs");
    debug_halt <= 1'b0;
    wr(`RDT_OFF_CTRL, 16'h0100);
    tick(0, 0, 2, 1'b0);
    rd(`RDT_OFF_CTRL, 16'h0100, "enable off");
    rd(`RDT_OFF_COUNT, m_cnt, "enable off count");
    idle(4);
    report_and_stop();
  end
endmodule
`default_nettype wire
